/* rtl/itpr_defs.svh */
// constants for the interval timer program and read-back block
// assumes it is included by bare name from rtl files
`ifndef ITPR_DEFS_SVH
`define ITPR_DEFS_SVH
`define ITPR_NUM_TIMERS 4
`define ITPR_PORT_CNT0 3'h0
`define ITPR_PORT_CNT1 3'h1
`define ITPR_PORT_CNT2 3'h2
`define ITPR_PORT_CTRL1 3'h3
`define ITPR_PORT_CNT3 3'h4
`define ITPR_PORT_CTRL2 3'h7
`define ITPR_SEL_MSB 7
`define ITPR_SEL_LSB 6
`define ITPR_RW_MSB 5
`define ITPR_RW_LSB 4
`define ITPR_MODE_MSB 3
`define ITPR_MODE_LSB 1
`define ITPR_BCD_BIT 0
`define ITPR_RW_LATCH 2'h0
`define ITPR_RW_LOW 2'h1
`define ITPR_RW_HIGH 2'h2
`define ITPR_RW_BOTH 2'h3
`define ITPR_SEL_READBACK 2'h3
`define ITPR_RB_NCOUNT_BIT 5
`define ITPR_RB_NSTATUS_BIT 4
`define ITPR_ST_OUT_BIT 7
`define ITPR_ST_NULL_BIT 6
`define ITPR_OUT_INIT 1'b1
`define ITPR_MODE_RESET 3'h0
`define ITPR_RW_RESET 2'h1
`endif

/* rtl/itpr_pkg.sv */
// types for the interval timer program and read-back block
// assumes nothing beyond the defs header
package itpr_pkg;
  typedef struct packed {
    logic [1:0] rw;
    logic [2:0] mode;
    logic bcd;
  } itpr_cfg_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] data;
  } itpr_bus_t;
endpackage : itpr_pkg

/* rtl/itpr_counter.sv */
// one 16-bit counting element and its load logic, fed from the count register held in itpr_top
// assumes clk_en marks a sampled timer clock edge and gate is synchronised
`timescale 1ns/10ps
`default_nettype none
`include "itpr_defs.svh"
module itpr_counter (
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic clk_en, // timer clock tick
  input wire logic gate, // counting enable
  input wire logic prog, // control word written
  input wire logic load, // new count complete
  input wire logic [15:0] cr, // count register value
  output logic [15:0] count, // live counting element
  output logic null_cnt, // count pending
  output logic timer_output_pin // output level
);
  logic [15:0] cnt_reg, cnt_next;
  logic null_reg, null_next;
  logic out_reg, out_next;

  // simple decrementing model; the mode is only stored for the status byte, no mode specific behaviour exists
  always_comb begin
    cnt_next = cnt_reg;
    null_next = null_reg;
    out_next = out_reg;
    if (prog) begin
      null_next = 1'b1;
      out_next = `ITPR_OUT_INIT;
    end
    if (load) begin
      null_next = 1'b1;
    end
    if (clk_en && null_reg && !load && !prog) begin
      cnt_next = cr;
      null_next = 1'b0;
    end else if (clk_en && gate && !null_reg && !prog) begin
      // a control word in the tick cycle wins over counting
      cnt_next = cnt_reg - 16'h0001;
      if (cnt_reg == 16'h0001) begin
        out_next = ~out_reg;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
      null_reg <= 1'b1;
      out_reg <= `ITPR_OUT_INIT;
    end else begin
      cnt_reg <= cnt_next;
      null_reg <= null_next;
      out_reg <= out_next;
    end
  end

  assign count = cnt_reg;
  assign null_cnt = null_reg;
  assign timer_output_pin = out_reg;
endmodule : itpr_counter
`default_nettype wire

/* rtl/itpr_top.sv */
// programming, latch and read-back logic for four interval timers
// assumes byte bus strobes are synchronous one-cycle pulses on MCLK_IN
`timescale 1ns/10ps
`default_nettype none
`include "itpr_defs.svh"
// Overview of operation
// - a control word resets that timer's control logic and output at once
// - count bytes follow the format: low only, high only, or low then high
// - a new count leaves the programmed mode untouched, same byte format
// - state after reset is not meaningful; software must program each timer
// - plain read returns the live count, only safe with clock held off
// - gate pins work on timers 2 and 3; timers 0 and 1 always enabled
// - a latch command is a zero access code; select field picks the timer
// - latch freezes the count until read or reprogrammed, counting unaffected
// - a second latch before reading is ignored
// - latched count is read in the programmed format; other timers may interleave
// - reads and writes of one timer interleave with separate byte pointers
// - read-back command selects several timers, each unlatched on its own read
// - repeated read-back count latches are ignored until read
// - status latch captures mode, output level and pending flag
// - pending flag shows count not yet moved into the counting element
// - repeated status latches are ignored until read
// - one read-back may latch both count and status
// - status is read first, then count bytes, then live count
module itpr_top #(
  parameter int NUM_TIMERS = `ITPR_NUM_TIMERS // timer count
) (
  input wire logic MCLK_IN, // 200 MHz system clock
  input wire logic RST_IN, // async reset, active high
  input wire logic WR_IN, // byte write strobe
  input wire logic RD_IN, // byte read strobe
  input wire logic [2:0] ADDR_IN, // register port
  input wire logic [7:0] DATA_IN, // write data
  output logic [7:0] DATA_OUT, // read data, registered
  input wire logic TCLK_IN, // shared timer clock pin
  input wire logic GATE2_IN, // gate pin of timer 2
  input wire logic GATE3_IN, // gate pin of timer 3
  output logic [3:0] TIMER_OUTPUT_PIN_OUT // timer output pins
);
  logic [2:0] tclk_sync_reg, tclk_sync_next;
  logic [1:0] g2_sync_reg, g2_sync_next;
  logic [1:0] g3_sync_reg, g3_sync_next;
  logic tick;
  logic [3:0] gate;
  itpr_pkg::itpr_bus_t bus;

  always_comb begin
    tclk_sync_next = {tclk_sync_reg[1:0], TCLK_IN};
    g2_sync_next = {g2_sync_reg[0], GATE2_IN};
    g3_sync_next = {g3_sync_reg[0], GATE3_IN};
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tclk_sync_reg <= 3'h0;
      g2_sync_reg <= 2'h0;
      g3_sync_reg <= 2'h0;
    end else begin
      tclk_sync_reg <= tclk_sync_next;
      g2_sync_reg <= g2_sync_next;
      g3_sync_reg <= g3_sync_next;
    end
  end

  // counting happens on the falling timer clock edge
  assign tick = tclk_sync_reg[2] & ~tclk_sync_reg[1];
  assign gate = {g3_sync_reg[1], g2_sync_reg[1], 1'b1, 1'b1};
  assign bus = '{wr: WR_IN, rd: RD_IN, addr: ADDR_IN, data: DATA_IN};

  logic is_ctrl1, is_ctrl2, is_ctrl;
  logic [1:0] sel;
  logic is_rb, is_latch, is_cw;
  assign is_ctrl1 = bus.wr && (bus.addr == `ITPR_PORT_CTRL1);
  assign is_ctrl2 = bus.wr && (bus.addr == `ITPR_PORT_CTRL2);
  assign is_ctrl = is_ctrl1 | is_ctrl2;
  assign sel = bus.data[`ITPR_SEL_MSB:`ITPR_SEL_LSB];
  // the second control port only addresses timer 3
  assign is_rb = is_ctrl && (sel == `ITPR_SEL_READBACK);
  assign is_latch = is_ctrl && !is_rb
    && (bus.data[`ITPR_RW_MSB:`ITPR_RW_LSB] == `ITPR_RW_LATCH);
  assign is_cw = is_ctrl && !is_rb && !is_latch;

  logic [7:0] rd_mux;
  logic [NUM_TIMERS-1:0] rd_hit;
  logic [7:0] rd_byte [NUM_TIMERS];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
      localparam logic [2:0] PORT = (gi == 3) ? `ITPR_PORT_CNT3 : 3'(gi);
      logic target, cw_hit, lat_hit, rbc_hit, rbs_hit, wr_hit;
      itpr_pkg::itpr_cfg_t cfg_reg, cfg_next;
      logic [15:0] cr_reg, cr_next;
      logic wr_hi_reg, wr_hi_next;
      logic rd_hi_reg, rd_hi_next;
      logic [15:0] ol_reg, ol_next;
      logic ol_held_reg, ol_held_next;
      logic [7:0] st_reg, st_next;
      logic st_held_reg, st_held_next;
      logic load;
      logic [15:0] count;
      logic null_cnt, timer_output_pin;

      assign target = is_ctrl2 ? (gi == 3) : (gi != 3) && (sel == 2'(gi));
      assign cw_hit = is_cw && target;
      assign lat_hit = is_latch && target;
      assign rbc_hit = is_rb && (is_ctrl2 ? (gi == 3) : (gi != 3) && bus.data[gi + 1])
        && !bus.data[`ITPR_RB_NCOUNT_BIT];
      assign rbs_hit = is_rb && (is_ctrl2 ? (gi == 3) : (gi != 3) && bus.data[gi + 1])
        && !bus.data[`ITPR_RB_NSTATUS_BIT];
      assign wr_hit = bus.wr && (bus.addr == PORT);
      assign rd_hit[gi] = bus.rd && (bus.addr == PORT);

      always_comb begin
        cfg_next = cfg_reg;
        cr_next = cr_reg;
        wr_hi_next = wr_hi_reg;
        rd_hi_next = rd_hi_reg;
        ol_next = ol_reg;
        ol_held_next = ol_held_reg;
        st_next = st_reg;
        st_held_next = st_held_reg;
        load = 1'b0;
        if (cw_hit) begin
          // mode set only here, never by count writes
          cfg_next.rw = bus.data[`ITPR_RW_MSB:`ITPR_RW_LSB];
          cfg_next.mode = bus.data[`ITPR_MODE_MSB:`ITPR_MODE_LSB];
          cfg_next.bcd = bus.data[`ITPR_BCD_BIT];
          wr_hi_next = 1'b0;
          rd_hi_next = 1'b0;
          ol_held_next = 1'b0;
          st_held_next = 1'b0;
        end
        if (wr_hit) begin
          case (cfg_reg.rw)
            `ITPR_RW_LOW: begin
              cr_next = {8'h00, bus.data};
              load = 1'b1;
            end
            `ITPR_RW_HIGH: begin
              cr_next = {bus.data, 8'h00};
              load = 1'b1;
            end
            `ITPR_RW_BOTH: begin
              if (wr_hi_reg) begin
                cr_next = {bus.data, cr_reg[7:0]};
                load = 1'b1;
              end else begin
                cr_next = {cr_reg[15:8], bus.data};
              end
              wr_hi_next = ~wr_hi_reg;
            end
            default: begin
              cr_next = cr_reg;
            end
          endcase
        end
        if ((lat_hit || rbc_hit) && !ol_held_reg) begin
          ol_next = count;
          ol_held_next = 1'b1;
        end
        if (rbs_hit && !st_held_reg) begin
          st_next = {timer_output_pin, null_cnt, cfg_reg.rw, cfg_reg.mode, cfg_reg.bcd};
          st_held_next = 1'b1;
        end
        if (rd_hit[gi]) begin
          if (st_held_reg) begin
            st_held_next = 1'b0;
          end else if (cfg_reg.rw == `ITPR_RW_BOTH) begin
            rd_hi_next = ~rd_hi_reg;
            if (rd_hi_reg) begin
              ol_held_next = 1'b0;
            end
          end else begin
            ol_held_next = 1'b0;
          end
        end
      end

      always_comb begin
        logic [15:0] src;
        src = ol_held_reg ? ol_reg : count;
        rd_byte[gi] = src[7:0];
        if (st_held_reg) begin
          rd_byte[gi] = st_reg;
        end else if (cfg_reg.rw == `ITPR_RW_HIGH
          || (cfg_reg.rw == `ITPR_RW_BOTH && rd_hi_reg)) begin
          rd_byte[gi] = src[15:8];
        end
      end

      always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          // reset values are not meaningful to software
          cfg_reg <= '{rw: `ITPR_RW_RESET, mode: `ITPR_MODE_RESET, bcd: 1'b0};
          cr_reg <= 16'h0000;
          wr_hi_reg <= 1'b0;
          rd_hi_reg <= 1'b0;
          ol_reg <= 16'h0000;
          ol_held_reg <= 1'b0;
          st_reg <= 8'h00;
          st_held_reg <= 1'b0;
        end else begin
          cfg_reg <= cfg_next;
          cr_reg <= cr_next;
          wr_hi_reg <= wr_hi_next;
          rd_hi_reg <= rd_hi_next;
          ol_reg <= ol_next;
          ol_held_reg <= ol_held_next;
          st_reg <= st_next;
          st_held_reg <= st_held_next;
        end
      end

      itpr_counter u_cnt (
        .clk(MCLK_IN),
        .rst(RST_IN),
        .clk_en(tick),
        .gate(gate[gi]),
        .prog(cw_hit),
        .load(load),
        .cr(cr_next),
        .count(count),
        .null_cnt(null_cnt),
        .timer_output_pin(timer_output_pin)
      );
      assign TIMER_OUTPUT_PIN_OUT[gi] = timer_output_pin;
    end
  endgenerate

  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (rd_hit[i]) begin
        rd_mux = rd_byte[i];
      end
    end
  end

  logic [7:0] dout_reg, dout_next;
  // data held after a read so the host can sample it next cycle
  assign dout_next = (|rd_hit) ? rd_mux : dout_reg;
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      dout_reg <= 8'h00;
    end else begin
      dout_reg <= dout_next;
    end
  end
  assign DATA_OUT = dout_reg;
endmodule : itpr_top
`default_nettype wire

/* bench/itpr_props.sv */
// port checker for the timer program and read-back block
// assumes binding to itpr_top, strobes one cycle long
`timescale 1ns/10ps
`default_nettype none
module itpr_props #(
  parameter int NUM_TIMERS = 4 // timers
) (
  input wire logic MCLK_IN, // clk
  input wire logic RST_IN, // rst
  input wire logic WR_IN, // wr
  input wire logic RD_IN, // rd
  input wire logic [2:0] ADDR_IN, // port
  input wire logic [7:0] DATA_IN, // wdata
  input wire logic [7:0] DATA_OUT, // rdata
  input wire logic TCLK_IN, // tclk
  input wire logic [3:0] TIMER_OUTPUT_PIN_OUT // outs
);
  logic [7:0] cw_reg;
  logic [7:0] cw_next;
  logic cw0;
  logic rb_st;
  // last timer 0 word predicts its status byte
  assign cw0 = WR_IN && ADDR_IN == 3'h3 && DATA_IN[7:6] == 2'h0 && DATA_IN[5:4] != 2'h0;
  assign rb_st = WR_IN && ADDR_IN == 3'h3 && DATA_IN == 8'he2;
  always_comb begin
    cw_next = cw0 ? DATA_IN : cw_reg;
  end
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cw_reg <= 8'h10;
    end else begin
      cw_reg <= cw_next;
    end
  end
  default clocking dc @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  chk_reset_vals: assert property ($fell(RST_IN) |-> TIMER_OUTPUT_PIN_OUT == 4'hf && DATA_OUT == 8'h00)
    else $error("reset values wrong");
  chk_out_init0: assert property (cw0 |-> ##[1:2] TIMER_OUTPUT_PIN_OUT[0])
    else $error("timer 0 output not set");
  chk_out_init3: assert property (WR_IN && ADDR_IN == 3'h7 && DATA_IN[7:6] != 2'h3
    && DATA_IN[5:4] != 2'h0 |-> ##[1:2] TIMER_OUTPUT_PIN_OUT[3]) else $error("timer 3 output not set");
  chk_rd_hold: assert property (!RD_IN |=> $stable(DATA_OUT))
    else $error("read data moved without a read");
  chk_rd_ctrl: assert property (RD_IN && ADDR_IN inside {3'h3, 3'h5, 3'h6, 3'h7}
    |=> $stable(DATA_OUT)) else $error("control port read changed data");
  chk_st_out: assert property (rb_st ##2 (RD_IN && ADDR_IN == 3'h0 && $stable(TIMER_OUTPUT_PIN_OUT))
    |=> $stable(TIMER_OUTPUT_PIN_OUT) && DATA_OUT[7] == TIMER_OUTPUT_PIN_OUT[0]) else $error("status output bit wrong");
  chk_st_fields: assert property (rb_st ##2 (RD_IN && ADDR_IN == 3'h0)
    |=> DATA_OUT[5:0] == cw_reg[5:0]) else $error("status fields wrong");
  chk_null_flag: assert property ((!TCLK_IN [*6] ##0 (WR_IN && ADDR_IN == 3'h0
    && cw_reg[5:4] == 2'h1)) ##1 !TCLK_IN ##1 (rb_st && !TCLK_IN) ##2 (RD_IN && ADDR_IN == 3'h0)
    |=> DATA_OUT[6]) else $error("pending flag not set");
endmodule : itpr_props
bind itpr_top itpr_props #(.NUM_TIMERS(NUM_TIMERS)) i_itpr_props (.MCLK_IN(MCLK_IN),
  .RST_IN(RST_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .ADDR_IN(ADDR_IN), .DATA_IN(DATA_IN),
  .DATA_OUT(DATA_OUT), .TCLK_IN(TCLK_IN), .TIMER_OUTPUT_PIN_OUT(TIMER_OUTPUT_PIN_OUT));
`default_nettype wire

/* bench/itpr_host_model.sv */
// host processor model issuing byte reads and writes
// assumes callers run whole sequences, one access at a time
`timescale 1ns/10ps
`default_nettype none
module itpr_host_model (
  input wire logic clk_in, // clock
  input wire logic [7:0] rdata_in, // read data
  output var itpr_pkg::itpr_bus_t bus_out // requests
);
  initial bus_out = '0;
  // released data shows its inverse, never a stale copy
  task automatic wr_b(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 bus_out = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge clk_in);
    #1 bus_out = '{wr: 1'b0, rd: 1'b0, addr: a, data: ~d};
  endtask : wr_b
  task automatic rd_b(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1 bus_out = '{wr: 1'b0, rd: 1'b1, addr: a, data: bus_out.data};
    @(posedge clk_in);
    #1 bus_out.rd = 1'b0;
    d = rdata_in;
  endtask : rd_b
endmodule : itpr_host_model
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the timer program and read-back block
// assumes the host model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [1:0] t; logic [1:0] rw; logic [15:0] v;} itpr_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic tclk = 1'b0;
  logic g2 = 1'b1;
  logic g3 = 1'b1;
  logic [7:0] dout;
  logic [3:0] timer_output_pin;
  logic [7:0] b;
  logic [15:0] got;
  itpr_pkg::itpr_bus_t bus;
  int n_errors = 0;
  int tests_run = 0;
  itpr_row_t rows [6] = '{'{2'h0, 2'h3, 16'h1234}, '{2'h1, 2'h1, 16'h00a5},
    '{2'h2, 2'h2, 16'h5a00}, '{2'h3, 2'h3, 16'hbeef}, '{2'h3, 2'h2, 16'h7f00},
    '{2'h0, 2'h1, 16'h0033}};
  always #2.5 mclk = ~mclk;
  itpr_host_model i_itpr_host_model (.clk_in(mclk), .rdata_in(dout), .bus_out(bus));
  itpr_top i_itpr_top (.MCLK_IN(mclk), .RST_IN(rst), .WR_IN(bus.wr), .RD_IN(bus.rd),
    .ADDR_IN(bus.addr), .DATA_IN(bus.data), .DATA_OUT(dout), .TCLK_IN(tclk),
    .GATE2_IN(g2), .GATE3_IN(g3), .TIMER_OUTPUT_PIN_OUT(timer_output_pin));
  task automatic wrap_up;
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_itpr_host_model.wr_b(a, d);
  endtask : wr
  task automatic rd(input logic [2:0] a);
    i_itpr_host_model.rd_b(a, b);
  endtask : rd
  function automatic logic [2:0] pa(input logic [1:0] t);
    return t == 2'h3 ? 3'h4 : {1'b0, t};
  endfunction : pa
  // format 0 turns the word into a latch command
  task automatic prog(input logic [1:0] t, input logic [1:0] rw);
    wr(t == 2'h3 ? 3'h7 : 3'h3, {t == 2'h3 ? 2'h0 : t, rw, 4'h0});
  endtask : prog
  task automatic load(input logic [1:0] t, input logic [1:0] rw, input logic [15:0] v);
    if (rw[0]) wr(pa(t), v[7:0]);
    if (rw[1]) wr(pa(t), v[15:8]);
  endtask : load
  task automatic rdc(input logic [1:0] t, input logic [1:0] rw);
    got = 16'h0000;
    if (rw[0]) begin
      rd(pa(t));
      got[7:0] = b;
    end
    if (rw[1]) begin
      rd(pa(t));
      got[15:8] = b;
    end
  endtask : rdc
  // long phases so the synchroniser sees each level
  task automatic tick;
    tclk = 1'b1;
    repeat (6) @(posedge mclk);
    #1 tclk = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
  endtask : tick
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge mclk);
    #1 check({timer_output_pin, 4'h0, dout}, 16'hf000);
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    foreach (rows[i]) begin
      prog(rows[i].t, rows[i].rw);
      load(rows[i].t, rows[i].rw, rows[i].v);
      tick();
      prog(rows[i].t, 2'h0);
      rdc(rows[i].t, rows[i].rw);
      check(got, rows[i].v & {{8{rows[i].rw[1]}}, {8{rows[i].rw[0]}}});
    end
    prog(2'h0, 2'h3);
    @(posedge mclk);
    #1 check({15'h0, timer_output_pin[0]}, 16'h0001);
    load(2'h0, 2'h3, 16'h1234);
    tick();
    prog(2'h0, 2'h0);
    tick();
    prog(2'h0, 2'h0);
    rdc(2'h0, 2'h3);
    check(got, 16'h1234);
    prog(2'h0, 2'h0);
    rdc(2'h0, 2'h3);
    check(got, 16'h1233);
    rdc(2'h0, 2'h3);
    check(got, 16'h1233);
    prog(2'h0, 2'h0);
    rd(3'h0);
    got[7:0] = b;
    wr(3'h0, 8'h78);
    rd(3'h1);
    rd(3'h0);
    got[15:8] = b;
    wr(3'h0, 8'h56);
    check(got, 16'h1233);
    tick();
    rdc(2'h0, 2'h3);
    check(got, 16'h5678);
    prog(2'h0, 2'h1);
    load(2'h0, 2'h1, 16'h0042);
    tick();
    wr(3'h0, 8'h99);
    wr(3'h3, 8'he2);
    rd(3'h0);
    check({9'h0, b[6:0]}, 16'h0050);
    wr(3'h3, 8'hc2);
    tick();
    wr(3'h3, 8'hc2);
    rd(3'h0);
    check({9'h0, b[6:0]}, 16'h0050);
    rd(3'h0);
    check({8'h0, b}, 16'h0042);
    rd(3'h0);
    check({8'h0, b}, 16'h0099);
    prog(2'h2, 2'h3);
    load(2'h2, 2'h3, 16'h0300);
    prog(2'h0, 2'h3);
    load(2'h0, 2'h3, 16'h0200);
    tick();
    wr(3'h3, 8'hda);
    tick();
    rdc(2'h2, 2'h3);
    check(got, 16'h0300);
    rdc(2'h0, 2'h3);
    check(got, 16'h0200);
    g2 = 1'b0;
    tick();
    rdc(2'h2, 2'h3);
    check(got, 16'h02ff);
    rdc(2'h0, 2'h3);
    check(got, 16'h01fe);
    rd(3'h5);
    check({8'h0, b}, 16'h0001);
    g2 = 1'b1;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
